//--- rdu_handler.sv
`timescale 1ns/1ps

module rdu_handler #(
	parameter logic [7:0] SET_DATA_CODE = 8'h01,
	parameter int         RSV_AW        = 6,
	parameter int         TXD_AW        = 7
) (
	input  wire logic                       CLK,
	input  wire logic                       RST_N,
	input  wire logic                       SETUP_VALID,
	input  wire logic [7:0]                 SETUP_TYPE,
	input  wire logic [7:0]                 SETUP_REQ,
	input  wire logic [15:0]                SETUP_VALUE,
	input  wire logic [15:0]                SETUP_INDEX,
	input  wire logic [15:0]                SETUP_LENGTH,
	input  wire rdu_pkg::rdu_dev_state_type DEV_STATE,
	input  wire logic                       DATA_VALID,
	input  wire logic [7:0]                 DATA_BYTE,
	input  wire logic                       DATA_DONE,
	input  wire logic                       DATA_ABORT,
	input  wire logic                       STATUS_SENT,
	input  wire logic                       BEACON_START,
	input  wire logic [7:0]                 CHAN_TAG,
	input  wire logic                       RSV_TX_FEATURE,
	input  wire logic [RSV_AW-1:0]          RSV_RD_ADDR,
	input  wire logic [TXD_AW-1:0]          TXD_RD_ADDR,
	output logic                            REQ_TAKEN,
	output logic                            REQ_ERROR,
	output logic                            RSV_PRESENT,
	output logic                            RSV_SEND,
	output logic [15:0]                     RSV_CTRL,
	output logic [15:0]                     RSV_LEN,
	output logic [7:0]                      RSV_RD_DATA,
	output logic                            TXD_VALID,
	output logic [15:0]                     TXD_LEN,
	output logic [7:0]                      TXD_RD_DATA,
	output logic [23:0]                     TX_TIME,
	output logic [7:0]                      TX_ADJUST,
	output logic [7:0]                      RX_FILTER,
	output logic [7:0]                      RX_CHANNEL,
	output logic [23:0]                     RX_START,
	output logic [23:0]                     RX_END,
	output logic [7:0]                      NOTIF_PWR,
	output logic [7:0]                      BEACON_PWR
);
	import rdu_pkg::*;

	localparam logic [15:0] RSV_CAP = 16'(2**RSV_AW) + RSV_BLOCK_OFS;
	localparam logic [15:0] TXD_CAP = 16'(2**TXD_AW);

	rdu_state_type state_q;
	logic [15:0]   sel_q;
	logic [15:0]   len_q;
	logic [15:0]   cnt_q;
	logic [7:0]    stg_q [0:STAGE_BYTES-1];
	logic [7:0]    attr_q;
	logic          rsv_bank_q;
	logic          rsv_pend_q;
	logic [7:0]    pend_attr_q;
	logic [15:0]   pend_len_q;
	logic          txd_bank_q;

	// ------------------------------------------------------------
	// setup decode
	// ------------------------------------------------------------
	logic        ours;
	logic        sel_ok;
	logic        len_ok;
	logic        state_ok;
	logic        bad;
	logic [15:0] len_m1;

	assign ours = SETUP_VALID && SETUP_TYPE == REQ_TYPE_STD_OUT
		&& SETUP_REQ == SET_DATA_CODE;
	assign sel_ok = SETUP_VALUE >= SEL_RSV_INFO
		&& SETUP_VALUE <= SEL_TX_POWER;
	assign len_m1 = SETUP_LENGTH - 16'h0001;

	always_comb begin
		len_ok = 1'b1;
		unique case (SETUP_VALUE)
			SEL_RSV_INFO: len_ok = SETUP_LENGTH <= RSV_CAP
				&& (len_m1 % RSV_BLOCK_BYTES) == 16'h0000;
			SEL_TX_DATA: len_ok = SETUP_LENGTH <= TXD_CAP;
			SEL_TX_PARAMS: len_ok = SETUP_LENGTH <= TXP_LEN;
			SEL_RX_PARAMS: len_ok = SETUP_LENGTH <= RXP_LEN;
			SEL_TX_POWER: len_ok = SETUP_LENGTH <= PWR_LEN;
			default: len_ok = 1'b1;
		endcase
	end

	// unauthenticated and default are left open; refusing is the safe choice
	assign state_ok = DEV_STATE == DEV_ADDRESSED
		|| DEV_STATE == DEV_CONFIGURED;
	assign bad = SETUP_INDEX != INDEX_REQUIRED || !sel_ok
		|| !len_ok || !state_ok;

	// ------------------------------------------------------------
	// data stage
	// ------------------------------------------------------------
	logic        recv_byte;
	logic        stage_ok;
	logic        commit;
	logic [15:0] cnt_m1;

	assign recv_byte = state_q == ST_RECV && DATA_VALID && !SETUP_VALID;
	assign stage_ok = cnt_q == len_q;
	assign commit = state_q == ST_WAIT && STATUS_SENT
		&& !SETUP_VALID;
	assign cnt_m1 = cnt_q - 16'h0001;

	// a fresh setup of our own request always cancels whatever was in flight
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= ST_IDLE;
		end else if (ours) begin
			if (bad || SETUP_LENGTH == 16'h0000) begin
				state_q <= ST_IDLE;
			end else begin
				state_q <= ST_RECV;
			end
		end else begin
			unique case (state_q)
				ST_IDLE: state_q <= ST_IDLE;
				ST_RECV: begin
					if (DATA_ABORT) begin
						state_q <= ST_IDLE;
					end else if (DATA_DONE) begin
						state_q <= stage_ok ? ST_WAIT : ST_IDLE;
					end
				end
				ST_WAIT: begin
					if (STATUS_SENT || DATA_ABORT) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sel_q <= 16'h0000;
			len_q <= 16'h0000;
			cnt_q <= 16'h0000;
		end else if (ours) begin
			sel_q <= SETUP_VALUE;
			len_q <= SETUP_LENGTH;
			cnt_q <= 16'h0000;
		end else if (recv_byte && cnt_q != len_q) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			REQ_TAKEN <= 1'b0;
			REQ_ERROR <= 1'b0;
		end else begin
			REQ_TAKEN <= ours && !bad;
			REQ_ERROR <= (ours && bad) || (!SETUP_VALID
				&& state_q == ST_RECV && DATA_DONE
				&& !DATA_ABORT && !stage_ok);
		end
	end

	// short payloads land in a byte stage, never straight in the outputs
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < STAGE_BYTES; i++) begin
				stg_q[i] <= BYTE_RESET;
			end
			attr_q <= BYTE_RESET;
		end else if (recv_byte && cnt_q < 16'(STAGE_BYTES)) begin
			stg_q[cnt_q[2:0]] <= DATA_BYTE;
			if (cnt_q == 16'h0000) begin
				attr_q <= DATA_BYTE;
			end
		end
	end

	// ------------------------------------------------------------
	// reservation element, two banks
	// ------------------------------------------------------------
	logic rsv_wr;
	logic rsv_flip;

	assign rsv_wr = recv_byte && sel_q == SEL_RSV_INFO
		&& cnt_q >= RSV_BLOCK_OFS && cnt_q != len_q;
	// no flip while the spare bank is being refilled
	assign rsv_flip = BEACON_START && rsv_pend_q
		&& !(state_q != ST_IDLE && sel_q == SEL_RSV_INFO);

	rdu_bank_ram #(
		.AW (RSV_AW + 1),
		.DW (8)
	) u_rsv_ram (
		.clk     (CLK),
		.wr_en   (rsv_wr),
		.wr_addr ({~rsv_bank_q, cnt_m1[RSV_AW-1:0]}),
		.wr_data (DATA_BYTE),
		.rd_addr ({rsv_bank_q, RSV_RD_ADDR}),
		.rd_data (RSV_RD_DATA)
	);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rsv_pend_q  <= 1'b0;
			pend_attr_q <= BYTE_RESET;
			pend_len_q  <= 16'h0000;
		end else if (commit && sel_q == SEL_RSV_INFO) begin
			rsv_pend_q  <= 1'b1;
			pend_attr_q <= attr_q;
			pend_len_q  <= len_q - RSV_BLOCK_OFS;
		end else if (rsv_flip) begin
			rsv_pend_q <= 1'b0;
		end
	end

	// swap at a beacon start, so the next beacon carries the update
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rsv_bank_q  <= 1'b0;
			RSV_PRESENT <= 1'b0;
			RSV_CTRL    <= 16'h0000;
			RSV_LEN     <= 16'h0000;
		end else if (rsv_flip) begin
			rsv_bank_q  <= ~rsv_bank_q;
			RSV_PRESENT <= 1'b1;
			RSV_CTRL    <= {CHAN_TAG, pend_attr_q};
			RSV_LEN     <= pend_len_q;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			RSV_SEND <= 1'b0;
		end else begin
			RSV_SEND <= RSV_TX_FEATURE && (RSV_PRESENT || rsv_flip);
		end
	end

	// ------------------------------------------------------------
	// transmit packet data, two banks
	// ------------------------------------------------------------
	logic txd_wr;

	assign txd_wr = recv_byte && sel_q == SEL_TX_DATA && cnt_q != len_q;

	rdu_bank_ram #(
		.AW (TXD_AW + 1),
		.DW (8)
	) u_txd_ram (
		.clk     (CLK),
		.wr_en   (txd_wr),
		.wr_addr ({~txd_bank_q, cnt_q[TXD_AW-1:0]}),
		.wr_data (DATA_BYTE),
		.rd_addr ({txd_bank_q, TXD_RD_ADDR}),
		.rd_data (TXD_RD_DATA)
	);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			txd_bank_q <= 1'b0;
			TXD_VALID  <= 1'b0;
			TXD_LEN    <= 16'h0000;
		end else if (commit && sel_q == SEL_TX_DATA) begin
			txd_bank_q <= ~txd_bank_q;
			TXD_VALID  <= 1'b1;
			TXD_LEN    <= len_q;
		end
	end

	// ------------------------------------------------------------
	// directed transmit and receive parameters
	// ------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			TX_TIME   <= TIME_RESET;
			TX_ADJUST <= BYTE_RESET;
		end else if (commit && sel_q == SEL_TX_PARAMS) begin
			TX_TIME   <= {stg_q[TXP_TIME_OFS + 2], stg_q[TXP_TIME_OFS + 1],
				stg_q[TXP_TIME_OFS]};
			TX_ADJUST <= stg_q[TXP_ADJ_OFS];
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			RX_FILTER  <= BYTE_RESET;
			RX_CHANNEL <= BYTE_RESET;
			RX_START   <= TIME_RESET;
			RX_END     <= TIME_RESET;
		end else if (commit && sel_q == SEL_RX_PARAMS) begin
			RX_FILTER  <= stg_q[RXP_FILTER_OFS];
			RX_CHANNEL <= stg_q[RXP_CHAN_OFS];
			RX_START   <= {stg_q[RXP_START_OFS + 2],
				stg_q[RXP_START_OFS + 1], stg_q[RXP_START_OFS]};
			RX_END     <= {stg_q[RXP_END_OFS + 2],
				stg_q[RXP_END_OFS + 1], stg_q[RXP_END_OFS]};
		end
	end

	// ------------------------------------------------------------
	// transmit power
	// ------------------------------------------------------------
	// zero steps below maximum means full power, so reset gives maximum
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			NOTIF_PWR  <= PWR_RESET;
			BEACON_PWR <= PWR_RESET;
		end else if (commit && sel_q == SEL_TX_POWER) begin
			NOTIF_PWR  <= stg_q[PWR_NOTIF_OFS];
			BEACON_PWR <= stg_q[PWR_BCN_OFS];
		end
	end

endmodule // rdu_handler

//--- rdu_pkg.sv
package rdu_pkg;

	// ------------------------------------------------------------
	// setup stage decode
	// ------------------------------------------------------------
	localparam logic [7:0]  REQ_TYPE_STD_OUT = 8'h00;
	localparam logic [15:0] INDEX_REQUIRED   = 16'h0000;

	localparam logic [15:0] SEL_RSV_INFO     = 16'h0001;
	localparam logic [15:0] SEL_TX_DATA      = 16'h0002;
	localparam logic [15:0] SEL_TX_PARAMS    = 16'h0003;
	localparam logic [15:0] SEL_RX_PARAMS    = 16'h0004;
	localparam logic [15:0] SEL_TX_POWER     = 16'h0005;

	// ------------------------------------------------------------
	// payload layouts
	// ------------------------------------------------------------
	localparam int          RSV_PRIO_MSB     = 2;
	localparam int          RSV_PRIO_LSB     = 0;
	localparam logic [15:0] RSV_BLOCK_OFS    = 16'h0001;
	localparam logic [15:0] RSV_BLOCK_BYTES  = 16'h0004;

	localparam logic [15:0] TXP_LEN          = 16'h0004;
	localparam int          TXP_TIME_OFS     = 0;
	localparam int          TXP_ADJ_OFS      = 3;

	localparam logic [15:0] RXP_LEN          = 16'h0008;
	localparam int          RXP_FILTER_OFS   = 0;
	localparam int          RXP_CHAN_OFS     = 1;
	localparam int          RXP_START_OFS    = 2;
	localparam int          RXP_END_OFS      = 5;

	localparam logic [15:0] PWR_LEN          = 16'h0002;
	localparam int          PWR_NOTIF_OFS    = 0;
	localparam int          PWR_BCN_OFS      = 1;

	localparam int          STAGE_BYTES      = 8;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  PWR_RESET        = 8'h00;
	localparam logic [23:0] TIME_RESET       = 24'h00_0000;
	localparam logic [7:0]  BYTE_RESET       = 8'h00;

	typedef enum logic [1:0] {
		DEV_UNAUTH     = 2'b00,
		DEV_DEFAULT    = 2'b01,
		DEV_ADDRESSED  = 2'b10,
		DEV_CONFIGURED = 2'b11
	} rdu_dev_state_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RECV = 2'b01,
		ST_WAIT = 2'b10
	} rdu_state_type;

endpackage

//--- rdu_bank_ram.sv
`timescale 1ns/1ps

module rdu_bank_ram #(
	parameter int AW = 7,
	parameter int DW = 8
) (
	input  wire logic          clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);

	logic [DW-1:0] mem [0:(2**AW)-1];

	// no reset on the array; readers only trust lengths that were committed
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule // rdu_bank_ram

//--- rdu_handler_assertions.sv
`timescale 1ns/1ps

module rdu_chk #(
	parameter logic [7:0] SET_DATA_CODE = 8'h01
) (
	input wire logic                       CLK,
	input wire logic                       RST_N,
	input wire logic                       SETUP_VALID,
	input wire logic [7:0]                 SETUP_TYPE,
	input wire logic [7:0]                 SETUP_REQ,
	input wire logic [15:0]                SETUP_VALUE,
	input wire logic [15:0]                SETUP_INDEX,
	input wire logic [15:0]                SETUP_LENGTH,
	input wire rdu_pkg::rdu_dev_state_type DEV_STATE,
	input wire logic                       STATUS_SENT,
	input wire logic                       BEACON_START,
	input wire logic                       REQ_TAKEN,
	input wire logic                       REQ_ERROR,
	input wire logic                       RSV_PRESENT,
	input wire logic [15:0]                RSV_CTRL,
	input wire logic                       TXD_VALID,
	input wire logic [7:0]                 NOTIF_PWR,
	input wire logic [7:0]                 BEACON_PWR
);
	import rdu_pkg::*;

	wire ours = SETUP_VALID && SETUP_TYPE == REQ_TYPE_STD_OUT
		&& SETUP_REQ == SET_DATA_CODE;

	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	AST_INDEX_ERR: assert property (
		ours && SETUP_INDEX != INDEX_REQUIRED |=> REQ_ERROR && !REQ_TAKEN)
		else $error("nonzero index not refused");
	AST_SEL_ERR: assert property (
		ours && (SETUP_VALUE == 16'h0000 || SETUP_VALUE > SEL_TX_POWER)
		|=> REQ_ERROR) else $error("reserved selector not refused");
	AST_STATE_ERR: assert property (
		ours && !DEV_STATE[1] |=> REQ_ERROR)
		else $error("request taken in early state");
	AST_PWR_TAKEN: assert property (
		ours && SETUP_INDEX == 16'h0000 && SETUP_VALUE == SEL_TX_POWER
		&& DEV_STATE[1] && SETUP_LENGTH == PWR_LEN |=> REQ_TAKEN)
		else $error("valid power request not taken");
	AST_FOREIGN: assert property (
		SETUP_VALID && SETUP_TYPE != REQ_TYPE_STD_OUT |=> !REQ_TAKEN)
		else $error("foreign request taken");
	AST_ONE_ANSWER: assert property (
		!(REQ_TAKEN && REQ_ERROR)) else $error("taken and error together");
	AST_PWR_COMMIT: assert property (
		$changed(NOTIF_PWR) || $changed(BEACON_PWR) |-> $past(STATUS_SENT))
		else $error("power changed without status handshake");
	AST_RSV_BEACON: assert property (
		$changed(RSV_CTRL) || $rose(RSV_PRESENT) |-> $past(BEACON_START))
		else $error("element swapped off a beacon start");
	AST_TXD_COMMIT: assert property (
		$rose(TXD_VALID) |-> $past(STATUS_SENT))
		else $error("transmit data committed early");

	cover property (ours ##1 REQ_TAKEN);
	cover property (ours ##1 REQ_ERROR);
	cover property ($rose(RSV_PRESENT));
endmodule // rdu_chk

bind rdu_handler rdu_chk #(.SET_DATA_CODE(SET_DATA_CODE)) i_chk (
	.CLK(CLK), .RST_N(RST_N), .SETUP_VALID(SETUP_VALID),
	.SETUP_TYPE(SETUP_TYPE), .SETUP_REQ(SETUP_REQ),
	.SETUP_VALUE(SETUP_VALUE), .SETUP_INDEX(SETUP_INDEX),
	.SETUP_LENGTH(SETUP_LENGTH), .DEV_STATE(DEV_STATE),
	.STATUS_SENT(STATUS_SENT), .BEACON_START(BEACON_START),
	.REQ_TAKEN(REQ_TAKEN), .REQ_ERROR(REQ_ERROR),
	.RSV_PRESENT(RSV_PRESENT), .RSV_CTRL(RSV_CTRL),
	.TXD_VALID(TXD_VALID), .NOTIF_PWR(NOTIF_PWR),
	.BEACON_PWR(BEACON_PWR));

//--- rdu_host_model.sv
`timescale 1ns/1ps

module rdu_host_model #(
	parameter logic [7:0] CODE = 8'h01
) (
	input  wire logic clk,
	output logic        setup_valid,
	output logic [7:0]  setup_type,
	output logic [7:0]  setup_req,
	output logic [15:0] setup_value,
	output logic [15:0] setup_index,
	output logic [15:0] setup_length,
	output logic        data_valid,
	output logic [7:0]  data_byte,
	output logic        data_done,
	output logic        data_abort,
	output logic        status_sent,
	output logic        beacon_start
);
	logic [7:0] pay [0:127];

	initial begin
		{setup_valid, data_valid, data_done, data_abort} = '0;
		{status_sent, beacon_start, setup_type, setup_req} = '0;
		{setup_value, setup_index, setup_length} = '0;
		data_byte = 8'h00;
	end

	task automatic setup(input logic [7:0] t, input logic [15:0] v, i, l);
		@(negedge clk);
		setup_type = t;
		setup_req = CODE;
		setup_value = v;
		setup_index = i;
		setup_length = l;
		setup_valid = 1'b1;
		@(negedge clk);
		setup_valid = 1'b0;
	endtask

	// done never shares the last byte's cycle
	task automatic data(input int n, input logic abort);
		for (int k = 0; k < n; k++) begin
			@(negedge clk);
			data_valid = 1'b1;
			data_byte = pay[k];
		end
		@(negedge clk);
		data_valid = 1'b0;
		// released line: no stale byte left on it
		data_byte = ~data_byte;
		data_done = !abort;
		data_abort = abort;
		@(negedge clk);
		data_done = 1'b0;
		data_abort = 1'b0;
	endtask

	// one idle edge first: back-to-back pulses never re-drive in one step
	task automatic pulse(input logic bcn);
		@(negedge clk);
		status_sent = !bcn;
		beacon_start = bcn;
		@(negedge clk);
		status_sent = 1'b0;
		beacon_start = 1'b0;
	endtask
endmodule // rdu_host_model

//--- radio_data_update_request_handler_tb.sv
`timescale 1ns/1ps

module radio_data_update_request_handler_tb;
	import rdu_pkg::*;

	localparam logic [7:0]  CODE = 8'h01;
	localparam logic [15:0] SEL_BAD [6] = '{16'h0000, 16'h0006,
		16'hFFFF, 16'h0005, 16'h0001, 16'h0003};

	logic clk, rst_n, feat, s_v, d_v, d_done, d_abort, st_s, bcn;
	logic req_taken, req_error, rsv_present, rsv_send, txd_valid;
	logic [7:0]  s_t, s_r, d_b, chan_tag, rsv_rd, txd_rd, tx_adj;
	logic [7:0]  rx_filter, rx_chan, npwr, bpwr, pn;
	logic [15:0] s_val, s_idx, s_len, rsv_ctrl, rsv_len, txd_len;
	logic [23:0] tx_time, rx_start, rx_end;
	logic [5:0]  rsv_addr;
	logic [6:0]  txd_addr;
	rdu_dev_state_type dev_state;
	int n_fail, checks, n;

	rdu_host_model #(.CODE(CODE)) i_host (.clk(clk), .setup_valid(s_v),
		.setup_type(s_t), .setup_req(s_r), .setup_value(s_val),
		.setup_index(s_idx), .setup_length(s_len), .data_valid(d_v),
		.data_byte(d_b), .data_done(d_done), .data_abort(d_abort),
		.status_sent(st_s), .beacon_start(bcn));

	rdu_handler #(.SET_DATA_CODE(CODE)) i_dut (.CLK(clk), .RST_N(rst_n),
		.SETUP_VALID(s_v), .SETUP_TYPE(s_t), .SETUP_REQ(s_r),
		.SETUP_VALUE(s_val), .SETUP_INDEX(s_idx), .SETUP_LENGTH(s_len),
		.DEV_STATE(dev_state), .DATA_VALID(d_v), .DATA_BYTE(d_b),
		.DATA_DONE(d_done), .DATA_ABORT(d_abort), .STATUS_SENT(st_s),
		.BEACON_START(bcn), .CHAN_TAG(chan_tag), .RSV_TX_FEATURE(feat),
		.RSV_RD_ADDR(rsv_addr), .TXD_RD_ADDR(txd_addr),
		.REQ_TAKEN(req_taken), .REQ_ERROR(req_error),
		.RSV_PRESENT(rsv_present), .RSV_SEND(rsv_send),
		.RSV_CTRL(rsv_ctrl), .RSV_LEN(rsv_len), .RSV_RD_DATA(rsv_rd),
		.TXD_VALID(txd_valid), .TXD_LEN(txd_len), .TXD_RD_DATA(txd_rd),
		.TX_TIME(tx_time), .TX_ADJUST(tx_adj), .RX_FILTER(rx_filter),
		.RX_CHANNEL(rx_chan), .RX_START(rx_start), .RX_END(rx_end),
		.NOTIF_PWR(npwr), .BEACON_PWR(bpwr));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// payload fields are little-endian
	function automatic logic [23:0] le(input int k, input int w);
		le = '0;
		for (int j = w - 1; j >= 0; j--) begin
			le = {le[15:0], i_host.pay[k + j]};
		end
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic final_report();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic req(input logic [15:0] sel, idx, len, input logic ok);
		i_host.setup(8'h00, sel, idx, len);
		chk("taken", {31'd0, ok}, {31'd0, req_taken});
		chk("error", {31'd0, !ok}, {31'd0, req_error});
	endtask

	task automatic run(input logic [15:0] sel, input int k);
		for (int j = 0; j < k; j++) begin
			i_host.pay[j] = 8'($urandom);
		end
		// host keeps the upper attribute bits clear
		if (sel == SEL_RSV_INFO) begin
			i_host.pay[0] = i_host.pay[0] & 8'h07;
		end
		req(sel, 16'h0000, 16'(k), 1'b1);
		i_host.data(k, 1'b0);
		chk("len_err", 1'b0, {31'd0, req_error});
		i_host.pulse(1'b0);
	endtask

	initial begin
		#1000000;
		n_fail++;
		final_report();
	end

	initial begin
		{rst_n, feat, chan_tag, rsv_addr, txd_addr} = '0;
		dev_state = DEV_ADDRESSED;
		{n_fail, checks} = '0;
		pn = 8'h00;
		void'($urandom(65518));
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		chk("npwr", 8'h00, npwr);
		chk("bpwr", 8'h00, bpwr);
		chk("txd_valid0", 1'b0, {31'd0, txd_valid});
		for (int c = 0; c < 6; c++) begin
			dev_state = rdu_dev_state_type'(c > 3 ? c - 4 : 3);
			req(SEL_BAD[c], 16'(c == 3 ? 1 + $urandom_range(9) : 0),
				PWR_LEN, 1'b0);
		end
		i_host.setup(8'h80, SEL_TX_POWER, 16'h0000, PWR_LEN);
		chk("foreign", 1'b0, {31'd0, req_taken | req_error});
		dev_state = DEV_ADDRESSED;
		repeat (3) begin
			run(SEL_TX_POWER, 2);
			chk("npwr", le(0, 1), npwr);
			chk("bpwr", le(1, 1), bpwr);
			pn = npwr;
		end
		req(SEL_TX_POWER, 16'h0000, PWR_LEN, 1'b1);
		i_host.data(1, 1'b1);
		i_host.pulse(1'b0);
		chk("abort_pwr", pn, npwr);
		req(SEL_TX_POWER, 16'h0000, PWR_LEN, 1'b1);
		i_host.data(1, 1'b0);
		chk("short_err", 1'b1, {31'd0, req_error});
		i_host.pulse(1'b0);
		chk("short_pwr", pn, npwr);
		dev_state = DEV_CONFIGURED;
		run(SEL_TX_PARAMS, 4);
		chk("tx_time", le(0, 3), tx_time);
		chk("tx_adj", le(3, 1), tx_adj);
		run(SEL_RX_PARAMS, 8);
		chk("rx_filter", le(0, 1), rx_filter);
		chk("rx_chan", le(1, 1), rx_chan);
		chk("rx_start", le(2, 3), rx_start);
		chk("rx_end", le(5, 3), rx_end);
		n = 1 + $urandom_range(15);
		run(SEL_TX_DATA, n);
		chk("txd_len", n, txd_len);
		chk("txd_valid", 1'b1, {31'd0, txd_valid});
		for (int k = 0; k < n; k++) begin
			txd_addr = 7'(k);
			@(negedge clk);
			chk("txd", i_host.pay[k], txd_rd);
		end
		for (int r = 0; r < 2; r++) begin
			feat = r[0];
			chan_tag = 8'($urandom);
			n = 1 + 4 * (1 + $urandom_range(2));
			run(SEL_RSV_INFO, n);
			chk("early", r, {31'd0, rsv_present});
			i_host.pulse(1'b1);
			i_host.pulse(1'b1);
			chk("present", 1'b1, {31'd0, rsv_present});
			chk("send", feat, {31'd0, rsv_send});
			chk("ctrl", {chan_tag, 5'd0, i_host.pay[0][2:0]},
				rsv_ctrl);
			chk("len", n - 1, rsv_len);
			for (int k = 1; k < n; k++) begin
				rsv_addr = 6'(k - 1);
				@(negedge clk);
				chk("blk", i_host.pay[k], rsv_rd);
			end
		end
		final_report();
	end
endmodule // radio_data_update_request_handler_tb
